// file: design/lrc_ldo_regulator_control.sv
`timescale 1ns/10ps
module lrc_ldo_regulator_control
  import lrc_pkg::*;
#(
  parameter logic [4:0] CODE_RESET = 5'h00
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [LRC_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [LRC_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // power state and sleep requests
  input  wire logic              device_active,
  input  wire logic              low_power_input_one,
  input  wire logic              low_power_input_two,
  input  wire logic              low_power_input_three,
  input  wire logic              pin_sleep_request,
  // to the analog output stages
  output      lrc_ldo_out_type [3:0] ldo_out
);
  lrc_main_st_type     st_reg;
  lrc_main_st_type     st_next;
  lrc_wr_type          wr;
  lrc_dec_type         wr_dec;
  lrc_dec_type         rd_dec;
  logic [9:0]          rd_idx;
  logic [31:0]         rd_data;
  lrc_chan_type [3:0]  chan;
  logic [3:0]          chan_on;
  logic                all_off;
  logic [3:0]          en_v;
  logic [3:0]          dis_v;
  logic [3:0]          slp_v;

  lrc_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr            (wr),
    .wr_ok         (wr_dec.hit && !wr_dec.ro),
    .rd_idx        (rd_idx),
    .rd_data       (rd_data),
    .rd_ok         (rd_dec.hit)
  );

  for (genvar g = 0; g < LRC_NUM; g++) begin : g_chan
    lrc_ldo_chan u_chan (
      .mode_word         (st_reg.mode[g]),
      .sleep_word        (st_reg.slp[g]),
      .enable_bit        (st_reg.ctl[g]),
      .sleep_reg_bit     (st_reg.ctl[LRC_CTL_SLP]),
      .device_active     (device_active),
      .low_power_inputs  ({low_power_input_three, low_power_input_two, low_power_input_one}),
      .pin_sleep_request (pin_sleep_request),
      .chan              (chan[g])
    );
    assign chan_on[g] = chan[g].on;
    assign en_v[g]    = st_reg.out[g].en;
    assign dis_v[g]   = st_reg.out[g].dis;
    assign slp_v[g]   = st_reg.out[g].slp;
  end

  assign wr_dec  = lrc_decode(wr.idx);
  assign rd_dec  = lrc_decode(rd_idx);
  // the float option needs another regulator still running
  assign all_off = ~|chan_on;

  always_comb begin
    case (rd_dec.kind)
      LRC_K_MODE: rd_data = {16'h0000, st_reg.mode[rd_dec.ch]};
      LRC_K_SLP:  rd_data = {16'h0000, st_reg.slp[rd_dec.ch]};
      LRC_K_CTL:  rd_data = {16'h0000, st_reg.ctl};
      default:    rd_data = {20'h0_0000, dis_v, slp_v, en_v};
    endcase
  end

  always_comb begin
    st_next = st_reg;
    if (wr.en && wr_dec.hit && !wr_dec.ro) begin
      case (wr_dec.kind)
        LRC_K_MODE: st_next.mode[wr_dec.ch] =
          lrc_merge(st_reg.mode[wr_dec.ch], wr.data, wr.strb, LRC_MODE_MASK);
        LRC_K_SLP: st_next.slp[wr_dec.ch] =
          lrc_merge(st_reg.slp[wr_dec.ch], wr.data, wr.strb, LRC_SLP_MASK);
        LRC_K_CTL: st_next.ctl = lrc_merge(st_reg.ctl, wr.data, wr.strb, LRC_CTL_MASK);
        default: st_next.ctl = st_reg.ctl;
      endcase
    end
    for (int i = 0; i < LRC_NUM; i++) begin
      st_next.out[i].en   = chan[i].on;
      st_next.out[i].sw   = chan[i].sw;
      st_next.out[i].dis  = !chan[i].on && (!chan[i].fl || all_off);
      st_next.out[i].slp  = chan[i].slp;
      st_next.out[i].code = chan[i].code;
      // switch mode carries no target voltage
      st_next.out[i].mv   = chan[i].sw ? 12'h000 : lrc_code_to_mv(chan[i].code);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      for (int i = 0; i < LRC_NUM; i++) begin
        st_reg.mode[i][LRC_CODE_W-1:0] <= CODE_RESET;
        st_reg.slp[i][LRC_CODE_W-1:0]  <= LRC_IMG_RST;
        // all four are off in reset, so every output discharges
        st_reg.out[i].dis              <= 1'b1;
        st_reg.out[i].code             <= CODE_RESET;
        st_reg.out[i].mv               <= lrc_code_to_mv(CODE_RESET);
      end
    end else begin
      st_reg <= st_next;
    end
  end

  assign ldo_out = st_reg.out;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_code_top;
    (st_reg.out[0].code == 5'h1f && !st_reg.out[0].sw) |-> st_reg.out[0].mv == 12'hce4;
  endproperty
  a_code_top: assert property (p_code_top)
    else $error("top code not 3300 mV");

  property p_code_mid;
    (st_reg.out[0].code == 5'h0f && !st_reg.out[0].sw) |-> st_reg.out[0].mv == 12'h672;
  endproperty
  a_code_mid: assert property (p_code_mid)
    else $error("code 0f not 1650 mV");

  property p_all_off;
    (en_v == 4'h0) |-> (dis_v == 4'hf);
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("all regulators off but an output floats");

  sequence s_pre_active;
    !device_active && st_reg.ctl[0];
  endsequence
  sequence s_go_active;
    device_active && st_reg.ctl[0] && !pin_sleep_request &&
      st_reg.slp[0][LRC_BEH_LO +: 2] != LRC_BEH_OFF;
  endsequence
  property p_enable_on_active;
    s_pre_active ##1 s_go_active |=> st_reg.out[0].en;
  endproperty
  a_enable_on_active: assert property (p_enable_on_active)
    else $error("enable not applied on reaching active state");

  for (genvar g = 0; g < LRC_NUM; g++) begin : g_chk
    property p_switch;
      $past(st_reg.mode[g][LRC_SW_BIT]) |-> st_reg.out[g].sw && st_reg.out[g].mv == 12'h000;
    endproperty
    a_switch: assert property (p_switch)
      else $error("switch mode still carries a voltage");

    property p_live_code;
      (!st_reg.out[g].slp && !st_reg.out[g].sw) |->
        st_reg.out[g].code == $past(st_reg.mode[g][LRC_CODE_W-1:0]);
    endproperty
    a_live_code: assert property (p_live_code)
      else $error("output code does not follow voltage code");

    property p_image_reset;
      $past(!aresetn) |-> st_reg.slp[g][LRC_CODE_W-1:0] == 5'h1c;
    endproperty
    a_image_reset: assert property (p_image_reset)
      else $error("image code reset value wrong");

    property p_image_use;
      (st_reg.out[g].slp && !st_reg.out[g].sw &&
        $past(st_reg.slp[g][LRC_BEH_LO +: 2]) == LRC_BEH_IMG) |->
        st_reg.out[g].code == $past(st_reg.slp[g][LRC_CODE_W-1:0]);
    endproperty
    a_image_use: assert property (p_image_use)
      else $error("sleep did not select image code");

    property p_sleep_off;
      (st_reg.out[g].slp && $past(st_reg.slp[g][LRC_BEH_LO +: 2]) == LRC_BEH_OFF) |->
        !st_reg.out[g].en;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
      else $error("sleep disable left output on");

    property p_src_two;
      ($past(st_reg.slp[g][LRC_SRC_LO +: 2]) == 2'h2 && !$past(pin_sleep_request)) |->
        st_reg.out[g].slp == $past(low_power_input_two);
    endproperty
    a_src_two: assert property (p_src_two)
      else $error("sleep source two not followed");

    property p_pin_all;
      $past(pin_sleep_request) |-> st_reg.out[g].slp;
    endproperty
    a_pin_all: assert property (p_pin_all)
      else $error("sleep pin did not reach every regulator");

    property p_float;
      (!st_reg.out[g].en && en_v != 4'h0) |->
        st_reg.out[g].dis == !$past(st_reg.mode[g][LRC_FLT_BIT]);
    endproperty
    a_float: assert property (p_float)
      else $error("discharge does not follow float bit");

    property p_inactive;
      !$past(device_active) |-> !st_reg.out[g].en;
    endproperty
    a_inactive: assert property (p_inactive)
      else $error("regulator on before active state");

    property p_reserved;
      (st_reg.out[g].slp && $past(st_reg.slp[g][LRC_BEH_LO + 1])) |->
        st_reg.out[g].en == $past(st_reg.ctl[g] && device_active) &&
        (st_reg.out[g].sw || st_reg.out[g].code == $past(st_reg.mode[g][LRC_CODE_W-1:0]));
    endproperty
    a_reserved: assert property (p_reserved)
      else $error("reserved behaviour changed code or enable");
  end
endmodule // lrc_ldo_regulator_control

// file: common/lrc_pkg.sv
// What this block does
// - switch bit set: current-limited switch, code ignored
// - code map: 0.9V+50mV steps, 1.8V+100mV steps
// - new voltage code applies live, no restart
// - separate image code per regulator, resets 11100
// - sleep with image behaviour uses image code
// - behaviour 00 image voltage, 01 output off
// - source 00 sleep bit, else low-power input
// - sleep bit and inputs are active high
// - sleep pin forces all regulators to sleep
// - disabled output: float bit 0 discharges, 1 floats
// - all four off: discharge all, ignore float
// - enable bits act only in active state
package lrc_pkg;
  localparam int LRC_NUM    = 4;
  localparam int LRC_AW     = 12;
  localparam int LRC_CODE_W = 5;
  // offsets are word indices, byte address is index times four
  localparam logic [3:0][9:0] LRC_IDX_MODE = {10'h0d1, 10'h0ce, 10'h0cb, 10'h0c8};
  localparam logic [3:0][9:0] LRC_IDX_SLP  = {10'h0d3, 10'h0d0, 10'h0cd, 10'h0ca};
  localparam logic [9:0]  LRC_IDX_CTL    = 10'h0e0;
  localparam logic [9:0]  LRC_IDX_STS    = 10'h0e1;
  localparam int          LRC_SW_BIT     = 14;
  localparam int          LRC_FLT_BIT    = 10;
  localparam int          LRC_BEH_LO     = 12;
  localparam int          LRC_SRC_LO     = 8;
  localparam int          LRC_CTL_SLP    = 4;
  localparam logic [15:0] LRC_MODE_MASK  = 16'h441f;
  localparam logic [15:0] LRC_SLP_MASK   = 16'h331f;
  localparam logic [15:0] LRC_CTL_MASK   = 16'h001f;
  localparam logic [4:0]  LRC_IMG_RST    = 5'h1c;
  localparam logic [1:0]  LRC_BEH_IMG    = 2'h0;
  localparam logic [1:0]  LRC_BEH_OFF    = 2'h1;
  localparam logic [1:0]  LRC_SRC_REG    = 2'h0;
  localparam logic [11:0] LRC_MV_LO_BASE = 12'h384;
  localparam logic [11:0] LRC_MV_LO_STEP = 12'h032;
  localparam logic [11:0] LRC_MV_HI_BASE = 12'h708;
  localparam logic [11:0] LRC_MV_HI_STEP = 12'h064;
  localparam logic [1:0]  LRC_OKAY       = 2'h0;
  localparam logic [1:0]  LRC_SLVERR     = 2'h2;
  localparam logic [1:0]  LRC_K_MODE     = 2'h0;
  localparam logic [1:0]  LRC_K_SLP      = 2'h1;
  localparam logic [1:0]  LRC_K_CTL      = 2'h2;
  localparam logic [1:0]  LRC_K_STS      = 2'h3;

  typedef struct packed {
    logic en; logic [9:0] idx; logic [31:0] data; logic [3:0] strb;
  } lrc_wr_type;
  typedef struct packed {logic hit; logic ro; logic [1:0] kind; logic [1:0] ch;} lrc_dec_type;
  typedef struct packed {logic on; logic sw; logic fl; logic slp; logic [4:0] code;} lrc_chan_type;
  typedef struct packed {
    logic en; logic sw; logic dis; logic slp; logic [4:0] code; logic [11:0] mv;
  } lrc_ldo_out_type;
  typedef struct packed {
    logic aw_got; logic w_got; logic [9:0] widx; logic [31:0] wdata; logic [3:0] wstrb;
    logic bvalid; logic [1:0] bresp; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } lrc_axi_st_type;
  typedef struct packed {
    logic [3:0][15:0] mode; logic [3:0][15:0] slp; logic [15:0] ctl;
    lrc_ldo_out_type [3:0] out;
  } lrc_main_st_type;

  function automatic lrc_dec_type lrc_decode(input logic [9:0] idx);
    lrc_dec_type d;
    d = '0;
    for (int i = 0; i < LRC_NUM; i++) begin
      if (idx == LRC_IDX_MODE[i]) d = '{1'b1, 1'b0, LRC_K_MODE, 2'(i)};
      if (idx == LRC_IDX_SLP[i]) d = '{1'b1, 1'b0, LRC_K_SLP, 2'(i)};
    end
    if (idx == LRC_IDX_CTL) d = '{1'b1, 1'b0, LRC_K_CTL, 2'h0};
    if (idx == LRC_IDX_STS) d = '{1'b1, 1'b1, LRC_K_STS, 2'h0};
    return d;
  endfunction

  function automatic logic [11:0] lrc_code_to_mv(input logic [4:0] c);
    logic [11:0] lo;
    logic [11:0] hi;
    lo = LRC_MV_LO_BASE + LRC_MV_LO_STEP * {8'h00, c[3:0]};
    hi = LRC_MV_HI_BASE + LRC_MV_HI_STEP * {8'h00, c[3:0]};
    return c[4] ? hi : lo;
  endfunction

  // only the two low byte lanes carry register bits
  function automatic logic [15:0] lrc_merge(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] n;
    n = old;
    if (strb[0]) n[7:0] = data[7:0];
    if (strb[1]) n[15:8] = data[15:8];
    return n & mask;
  endfunction
endpackage

// file: design/lrc_axil_slave.sv
`timescale 1ns/10ps
module lrc_axil_slave
  import lrc_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [LRC_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [LRC_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // register file side
  output      lrc_wr_type        wr,
  input  wire logic              wr_ok,
  output      logic [9:0]        rd_idx,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_ok
);
  lrc_axi_st_type s_reg;
  lrc_axi_st_type s_next;

  always_comb begin
    s_next        = s_reg;
    // no new address until the response is gone: one write in flight
    s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
    s_axi_wready  = !s_reg.w_got && !s_reg.bvalid;
    s_axi_arready = !s_reg.rvalid;
    rd_idx        = s_axi_araddr[LRC_AW-1:2];
    wr            = '{s_reg.aw_got && s_reg.w_got, s_reg.widx, s_reg.wdata, s_reg.wstrb};
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_got = 1'b1;
      s_next.widx   = s_axi_awaddr[LRC_AW-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (wr.en) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = wr_ok ? LRC_OKAY : LRC_SLVERR;
    end
    if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = rd_ok ? rd_data : 32'h0000_0000;
      s_next.rresp  = rd_ok ? LRC_OKAY : LRC_SLVERR;
    end
    if (s_reg.rvalid && s_axi_rready) s_next.rvalid = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp  = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata  = s_reg.rdata;
  assign s_axi_rresp  = s_reg.rresp;
endmodule // lrc_axil_slave

// file: design/lrc_ldo_chan.sv
`timescale 1ns/10ps
module lrc_ldo_chan
  import lrc_pkg::*;
(
  // register words
  input  wire logic [15:0] mode_word,
  input  wire logic [15:0] sleep_word,
  input  wire logic        enable_bit,
  input  wire logic        sleep_reg_bit,
  // power state and sleep inputs
  input  wire logic        device_active,
  input  wire logic [2:0]  low_power_inputs,
  input  wire logic        pin_sleep_request,
  // decision
  output      lrc_chan_type chan
);
  logic [1:0] src;
  logic [1:0] beh;
  logic       req;

  always_comb begin
    src = sleep_word[LRC_SRC_LO +: 2];
    beh = sleep_word[LRC_BEH_LO +: 2];
    // all sources active high
    if (src == LRC_SRC_REG) req = sleep_reg_bit;
    else req = low_power_inputs[src - 2'h1];
    req       = req | pin_sleep_request;
    // enable held back until the active state
    chan.on   = enable_bit & device_active;
    chan.sw   = mode_word[LRC_SW_BIT];
    chan.fl   = mode_word[LRC_FLT_BIT];
    chan.slp  = req;
    chan.code = mode_word[LRC_CODE_W-1:0];
    if (req) begin
      case (beh)
        LRC_BEH_IMG: chan.code = sleep_word[LRC_CODE_W-1:0];
        LRC_BEH_OFF: chan.on = 1'b0;
        default: chan.code = mode_word[LRC_CODE_W-1:0];
      endcase
    end
    if (chan.sw) chan.code = '0;
  end
endmodule // lrc_ldo_chan

// file: verif/lrc_ldo_stage_model.sv
`timescale 1ns/10ps
module lrc_ldo_stage_model
  import lrc_pkg::*;
#(
  parameter logic [11:0] SUPPLY_MV = 12'h0e10
) (
  // clock
  input  wire logic            aclk,
  // control from the block
  input  wire lrc_ldo_out_type ldo_in,
  // modelled output level
  output      logic [11:0]     vout_mv
);
  initial vout_mv = 12'h000;

  // floating output toggles so it never passes as a held level
  always @(posedge aclk) begin
    if (ldo_in.en && ldo_in.sw) begin
      vout_mv <= SUPPLY_MV;
    end else if (ldo_in.en) begin
      vout_mv <= ldo_in.mv;
    end else if (ldo_in.dis) begin
      vout_mv <= 12'h000;
    end else begin
      vout_mv <= ~vout_mv;
    end
  end
endmodule // lrc_ldo_stage_model

// file: verif/lrc_ldo_regulator_control_tb_top.sv
`timescale 1ns/10ps
module lrc_ldo_regulator_control_tb_top
  import lrc_pkg::*;
;
  localparam logic [4:0]  VRST  = 5'h05;
  localparam logic [11:0] CTL_A = {LRC_IDX_CTL, 2'b00};
  localparam logic [11:0] STS_A = {LRC_IDX_STS, 2'b00};

  logic                  aclk                  = 1'b0;
  logic                  aresetn               = 1'b0;
  logic [11:0]           s_axi_awaddr          = '0;
  logic [11:0]           s_axi_araddr          = '0;
  logic [31:0]           s_axi_wdata           = '0;
  logic [3:0]            s_axi_wstrb           = '0;
  logic                  s_axi_awvalid         = 1'b0;
  logic                  s_axi_wvalid          = 1'b0;
  logic                  s_axi_bready          = 1'b0;
  logic                  s_axi_arvalid         = 1'b0;
  logic                  s_axi_rready          = 1'b0;
  logic                  device_active         = 1'b1;
  logic                  low_power_input_one   = 1'b0;
  logic                  low_power_input_two   = 1'b0;
  logic                  low_power_input_three = 1'b0;
  logic                  pin_sleep_request     = 1'b0;
  logic                  s_axi_awready;
  logic                  s_axi_wready;
  logic                  s_axi_bvalid;
  logic                  s_axi_arready;
  logic                  s_axi_rvalid;
  logic [1:0]            s_axi_bresp;
  logic [1:0]            s_axi_rresp;
  logic [31:0]           s_axi_rdata;
  lrc_ldo_out_type [3:0] ldo_out;
  logic [3:0][11:0]      vout;
  logic [31:0]           rv;
  logic [1:0]            rr;
  int                    n_mismatch = 0;
  int                    n_tests    = 0;
  int                    cyc        = 0;

  always #2 aclk = ~aclk;

  lrc_ldo_regulator_control #(.CODE_RESET(VRST)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .device_active, .low_power_input_one,
    .low_power_input_two, .low_power_input_three, .pin_sleep_request, .ldo_out
  );

  for (genvar g = 0; g < LRC_NUM; g++) begin : g_stage
    lrc_ldo_stage_model i_stage (.aclk(aclk), .ldo_in(ldo_out[g]), .vout_mv(vout[g]));
  end

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // the whole run needs well under two thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chb(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ao;
    logic wo;
    ao = 1'b1;
    wo = 1'b1;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (ao && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        ao = 1'b0;
      end
      if (wo && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        wo = 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ao;
    ao = 1'b1;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (ao && s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
        ao = 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    axr(a, rv, rr);
    chk(rv, e);
    chk({30'h0, rr}, {30'h0, LRC_OKAY});
  endtask

  function automatic logic [11:0] ma(input int i);
    return {LRC_IDX_MODE[i], 2'b00};
  endfunction

  function automatic logic [11:0] sa(input int i);
    return {LRC_IDX_SLP[i], 2'b00};
  endfunction

  function automatic logic [11:0] mv_of(input logic [4:0] c);
    if (c[4]) begin
      return 12'h708 + 12'h064 * {8'h00, c[3:0]};
    end
    return 12'h384 + 12'h032 * {8'h00, c[3:0]};
  endfunction

  function automatic lrc_ldo_out_type ex(input logic en, sw, dis, slp, input logic [4:0] c);
    return '{en, sw, dis, slp, sw ? 5'h00 : c, sw ? 12'h000 : mv_of(c)};
  endfunction

  task automatic ckl(input int i, input lrc_ldo_out_type e);
    chk(32'(ldo_out[i]), 32'(e));
  endtask

  task automatic settle();
    repeat (4) @(posedge aclk);
  endtask

  // bit 0 is the sleep register bit, bits 3..1 the pins, taken as configured
  task automatic set_req(input logic [3:0] m);
    low_power_input_one   <= m[1];
    low_power_input_two   <= m[2];
    low_power_input_three <= m[3];
    axw(CTL_A, {27'h0, m[0], 4'hf}, LRC_OKAY);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    ckl(0, ex(1'b0, 1'b0, 1'b1, 1'b0, VRST));
    for (int i = 0; i < LRC_NUM; i++) begin
      rdc(ma(i), {27'h0, VRST});
      rdc(sa(i), 32'h0000_001c);
    end
    axr(12'h3fc, rv, rr);
    chk({30'h0, rr}, {30'h0, LRC_SLVERR});
    chk(rv, 32'h0000_0000);
    axw(STS_A, 32'h0000_0fff, LRC_SLVERR);
    axw(ma(0), 32'h0000_ffff, LRC_OKAY);
    rdc(ma(0), 32'h0000_441f);
    $display("test registers done");
    // no disable between codes: each one must land live
    axw(CTL_A, 32'h0000_0001, LRC_OKAY);
    for (int c = 0; c < 32; c++) begin
      axw(ma(0), 32'(c), LRC_OKAY);
      settle();
      ckl(0, ex(1'b1, 1'b0, 1'b0, 1'b0, 5'(c)));
    end
    $display("test voltage codes done");
    axw(ma(0), 32'h0000_4007, LRC_OKAY);
    settle();
    ckl(0, ex(1'b1, 1'b1, 1'b0, 1'b0, 5'h07));
    chk({20'h0, vout[0]}, 32'h0000_0e10);
    axw(ma(0), 32'h0000_0007, LRC_OKAY);
    $display("test switch mode done");
    axw(ma(1), 32'h0000_000a, LRC_OKAY);
    for (int s = 0; s < 4; s++) begin
      axw(sa(1), {22'h0, 2'(s), 8'h03}, LRC_OKAY);
      set_req(4'hf & ~(4'h1 << s));
      settle();
      ckl(1, ex(1'b1, 1'b0, 1'b0, 1'b0, 5'h0a));
      set_req(4'h1 << s);
      settle();
      ckl(1, ex(1'b1, 1'b0, 1'b0, 1'b1, 5'h03));
    end
    $display("test sleep sources done");
    set_req(4'h2);
    for (int b = 1; b < 4; b++) begin
      axw(sa(1), {18'h0, 2'(b), 4'h1, 8'h03}, LRC_OKAY);
      settle();
      if (b == 1) begin
        ckl(1, ex(1'b0, 1'b0, 1'b1, 1'b1, 5'h0a));
      end else begin
        ckl(1, ex(1'b1, 1'b0, 1'b0, 1'b1, 5'h0a));
      end
    end
    set_req(4'h0);
    $display("test sleep behaviour done");
    pin_sleep_request <= 1'b1;
    settle();
    for (int i = 0; i < LRC_NUM; i++) begin
      chb(ldo_out[i].slp, 1'b1);
    end
    ckl(0, ex(1'b1, 1'b0, 1'b0, 1'b1, 5'h1c));
    pin_sleep_request <= 1'b0;
    settle();
    chb(ldo_out[1].slp, 1'b0);
    $display("test sleep pin done");
    axw(ma(0), 32'h0000_0407, LRC_OKAY);
    axw(ma(2), 32'h0000_0404, LRC_OKAY);
    axw(CTL_A, 32'h0000_000b, LRC_OKAY);
    settle();
    chb(ldo_out[2].dis, 1'b0);
    axw(ma(2), 32'h0000_0004, LRC_OKAY);
    settle();
    chb(ldo_out[2].dis, 1'b1);
    chk({20'h0, vout[2]}, 32'h0000_0000);
    axw(ma(2), 32'h0000_0404, LRC_OKAY);
    axw(CTL_A, 32'h0000_0000, LRC_OKAY);
    settle();
    for (int i = 0; i < LRC_NUM; i++) begin
      chb(ldo_out[i].dis, 1'b1);
    end
    $display("test output float done");
    device_active <= 1'b0;
    axw(CTL_A, 32'h0000_000f, LRC_OKAY);
    settle();
    chb(ldo_out[3].en, 1'b0);
    device_active <= 1'b1;
    settle();
    chb(ldo_out[3].en, 1'b1);
    rdc(STS_A, 32'h0000_000f);
    $display("test active state done");
    stop_test();
  end
endmodule // lrc_ldo_regulator_control_tb_top
